/* File: include/cmpc_pkg.sv */
// Purpose: Shared constants and types for the clock mode and power control block
// Assumes: One oscillator clock, register port with one-cycle read latency
// Notes: Offsets are register indices on the plain register port
package cmpc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_CLK_DIV_CFG = 2'h0;
    localparam logic [1:0] ADDR_PWR_CTRL = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam logic [7:0] CLK_DIV_CFG_RESET = 8'h00;
    localparam logic [7:0] CLK_DIV_CFG_MASK = 8'h7f;
    localparam int BIT_CPU_X = 0;
    localparam int BIT_IDLE_REQ = 0;
    localparam int BIT_PD_REQ = 1;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [3:0] DIV_FAST = 4'h6;
    localparam logic [3:0] DIV_SLOW = 4'hc;
    localparam logic [4:0] RST_HOLD_FAST = 5'h0c;
    localparam logic [4:0] RST_HOLD_SLOW = 5'h18;
    localparam int NUM_PERIPH = 6;
    typedef enum logic [1:0] {
        CMPC_RUN = 2'b00,
        CMPC_IDLE = 2'b01,
        CMPC_PD = 2'b11,
        CMPC_WAKE = 2'b10
    } cmpc_state_type;
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cmpc_bus_type;
endpackage

/* File: src/cmpc_top.sv */
// Purpose: Clock rate selection, reset qualification and low-power sequencing
// Assumes: One oscillator clock clk_sys; no derived clocks are made
// Notes: Enables are one-cycle strobes; peripheral order wd, ca, ser, t2, t1, t0
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module cmpc_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reset_pin,
    input wire logic double_speed_fuse,
    input wire logic external_access_pin,
    input wire logic ext_irq_0_n,
    input wire logic ext_irq_1_n,
    input wire logic irq_pending,
    input wire logic serial_fixed_mode,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic core_reset,
    output logic port_reset,
    output logic ea_latched,
    output logic cpu_run,
    output logic osc_enable,
    output logic machine_cycle_en,
    output logic watchdog_clk_en,
    output logic counter_array_clk_en,
    output logic serial_clk_en,
    output logic timer2_clk_en,
    output logic timer1_clk_en,
    output logic timer0_clk_en,
    output logic double_speed_active
);
    cmpc_pkg::cmpc_bus_type bus;
    cmpc_pkg::cmpc_state_type state, next_state;
    logic [7:0] clock_divider_config;
    logic [1:0] pwr_ctrl;
    logic [3:0] cnt6;
    logic half;
    logic [4:0] rst_cnt;
    logic rst_s1, rst_s2, i0_s1, i0_s2, i1_s1, i1_s2, ea_s1, ea_s2;
    logic rst_acc, rst_acc_q;
    logic [7:0] next_rdata;
    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {rst_s1, rst_s2, i0_s1, i0_s2} <= 4'h0;
            {i1_s1, i1_s2, ea_s1, ea_s2} <= 4'h0;
        end else begin
            {rst_s1, rst_s2} <= {reset_pin, rst_s1};
            {i0_s1, i0_s2} <= {ext_irq_0_n, i0_s1};
            {i1_s1, i1_s2} <= {ext_irq_1_n, i1_s1};
            {ea_s1, ea_s2} <= {external_access_pin, ea_s1};
        end
    end

    // ------------------------------------------------------------
    // Clock mode and dividers
    // ------------------------------------------------------------
    // Fuse overrides register bit; both clear after reset gives 12-clock
    assign double_speed_active = double_speed_fuse
        | clock_divider_config[cmpc_pkg::BIT_CPU_X];
    wire tick6 = (cnt6 == cmpc_pkg::DIV_FAST - 4'h1);
    wire tick12 = tick6 & half;
    // Divider keeps counting in idle so peripherals stay clocked
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt6 <= 4'h0;
            half <= 1'b0;
        end else if (osc_enable) begin
            cnt6 <= tick6 ? 4'h0 : cnt6 + 4'h1;
            half <= tick6 ? ~half : half;
        end
    end
    wire mc_tick = double_speed_active ? tick6 : tick12;
    wire [5:0] sel_slow;
    wire [5:0] periph_en;
    // Peripheral bits only honoured while double speed is active
    assign sel_slow = double_speed_active ? clock_divider_config[6:1] : 6'h3f;
    genvar g;
    generate
        for (g = 0; g < cmpc_pkg::NUM_PERIPH; g++) begin : g_en
            assign periph_en[g] = osc_enable & (sel_slow[g] ? tick12 : tick6);
        end
    endgenerate
    assign machine_cycle_en = osc_enable & mc_tick & cpu_run;
    assign timer0_clk_en = periph_en[0];
    assign timer1_clk_en = periph_en[1];
    assign timer2_clk_en = periph_en[2];
    // Variable-rate serial modes take timing from timers instead
    assign serial_clk_en = serial_fixed_mode ? periph_en[3] : 1'b0;
    assign counter_array_clk_en = periph_en[4];
    assign watchdog_clk_en = periph_en[5];

    // ------------------------------------------------------------
    // Reset qualification
    // ------------------------------------------------------------
    wire [4:0] hold_need = double_speed_active ? cmpc_pkg::RST_HOLD_FAST
                                               : cmpc_pkg::RST_HOLD_SLOW;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt <= 5'h00;
            rst_acc_q <= 1'b0;
            ea_latched <= 1'b0;
        end else begin
            rst_cnt <= !rst_s2 ? 5'h00 : (rst_acc ? rst_cnt : rst_cnt + 5'h01);
            rst_acc_q <= rst_acc;
            if (rst_acc_q && !rst_acc)
                ea_latched <= ea_s2;
        end
    end
    // Sticky: clearing the config bit would raise the hold and drop an accepted reset
    assign rst_acc = rst_s2 && ((rst_cnt >= hold_need) || rst_acc_q);
    assign core_reset = rst_acc;
    // Raw pin path, no clock needed
    assign port_reset = reset_pin | ~rst_n;

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    wire irq_low = ~i0_s2 | ~i1_s2;
    always_comb begin
        next_state = state;
        unique case (state)
            cmpc_pkg::CMPC_RUN:
                if (pwr_ctrl[cmpc_pkg::BIT_PD_REQ]) next_state = cmpc_pkg::CMPC_PD;
                else if (pwr_ctrl[cmpc_pkg::BIT_IDLE_REQ]) next_state = cmpc_pkg::CMPC_IDLE;
            cmpc_pkg::CMPC_IDLE:
                if (irq_pending) next_state = cmpc_pkg::CMPC_RUN;
            cmpc_pkg::CMPC_PD:
                if (irq_low) next_state = cmpc_pkg::CMPC_WAKE;
            cmpc_pkg::CMPC_WAKE:
                if (!irq_low) next_state = cmpc_pkg::CMPC_RUN;
        endcase
    end
    // Reset exit from any mode; RAM lives outside and is untouched
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= cmpc_pkg::CMPC_RUN;
        end else if (rst_acc) begin
            state <= cmpc_pkg::CMPC_RUN;
        end else begin
            state <= next_state;
        end
    end
    // Oscillator stays off in power down until a waking low level appears or the synchronised reset pin goes high
    assign osc_enable = (state != cmpc_pkg::CMPC_PD) | rst_s2;
    assign cpu_run = (state == cmpc_pkg::CMPC_RUN) & ~rst_acc;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    wire wr_cfg = bus.wr & (bus.addr == cmpc_pkg::ADDR_CLK_DIV_CFG);
    wire wr_pwr = bus.wr & (bus.addr == cmpc_pkg::ADDR_PWR_CTRL);
    wire leave_mode = (state != cmpc_pkg::CMPC_RUN) & (next_state == cmpc_pkg::CMPC_RUN);
    // Contents hold with no clock edges; reset clears both, and leaving a low-power mode also clears pwr_ctrl
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clock_divider_config <= cmpc_pkg::CLK_DIV_CFG_RESET;
            pwr_ctrl <= 2'h0;
        end else if (rst_acc) begin
            clock_divider_config <= cmpc_pkg::CLK_DIV_CFG_RESET;
            pwr_ctrl <= 2'h0;
        end else begin
            if (wr_cfg)
                clock_divider_config <= bus.wdata & cmpc_pkg::CLK_DIV_CFG_MASK;
            if (leave_mode)
                pwr_ctrl <= 2'h0;
            else if (wr_pwr)
                pwr_ctrl <= bus.wdata[1:0];
        end
    end
    always_comb begin
        next_rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                cmpc_pkg::ADDR_CLK_DIV_CFG: next_rdata = clock_divider_config;
                cmpc_pkg::ADDR_PWR_CTRL: next_rdata = {6'h00, pwr_ctrl};
                cmpc_pkg::ADDR_STATUS: next_rdata = {3'h0, ea_latched, double_speed_active,
                                                     rst_acc, state};
                default: next_rdata = 8'h00;
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) reg_rdata <= 8'h00;
        else reg_rdata <= next_rdata;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    fuse_override_a: assert property (double_speed_fuse |-> double_speed_active)
        else $error("fuse did not force double speed");
    slow_periph_a: assert property (!double_speed_active |-> (timer0_clk_en == (tick12 & osc_enable)))
        else $error("peripheral not at slow rate");
    fast_sel_a: assert property ((double_speed_active && !clock_divider_config[1])
        |-> (timer0_clk_en == (tick6 & osc_enable)))
        else $error("peripheral fast select ignored");
    serial_var_a: assert property (!serial_fixed_mode |-> !serial_clk_en)
        else $error("serial enable in variable mode");
    rst_hold_a: assert property ($rose(rst_acc) |-> $past(rst_cnt) >= 5'h0b)
        else $error("reset taken too early");
    port_rst_a: assert property (reset_pin |-> port_reset)
        else $error("ports not in reset");
    pd_prio_a: assert property ((state == cmpc_pkg::CMPC_RUN && pwr_ctrl == 2'h3 && !rst_acc)
        |=> state == cmpc_pkg::CMPC_PD)
        else $error("power down lost priority");
    pd_halt_a: assert property ((state == cmpc_pkg::CMPC_PD) |-> !machine_cycle_en)
        else $error("instruction ran in power down");
    idle_periph_a: assert property ((state == cmpc_pkg::CMPC_IDLE) |-> osc_enable && !cpu_run)
        else $error("idle clocks wrong");
    ea_hold_a: assert property (!(rst_acc_q && !rst_acc) |=> $stable(ea_latched))
        else $error("access latch changed");
    cov_idle_c: cover property (state == cmpc_pkg::CMPC_IDLE ##1 state == cmpc_pkg::CMPC_RUN);
    cov_wake_c: cover property (state == cmpc_pkg::CMPC_WAKE ##1 state == cmpc_pkg::CMPC_RUN);
    cov_rst_c: cover property ($rose(rst_acc));
    cov_fuse_c: cover property (double_speed_fuse && timer0_clk_en);
    cov_prio_c: cover property (state == cmpc_pkg::CMPC_RUN && pwr_ctrl == 2'h3);

    // ------------------------------------------------------------
    // Mode and reset sequencing checks
    // ------------------------------------------------------------
    rst_sticky_a: assert property ((rst_acc && rst_s1) |=> rst_acc)
        else $error("accepted reset dropped early");
    ea_latch_a: assert property ((rst_acc_q && !rst_acc) |=> ea_latched == $past(ea_s2))
        else $error("access pin not latched");
    cfg_clear_a: assert property (rst_acc |=> clock_divider_config == 8'h00)
        else $error("config not cleared by reset");
    cfg_keep_a: assert property ((state != cmpc_pkg::CMPC_RUN && !wr_cfg && !rst_acc)
        |=> $stable(clock_divider_config))
        else $error("config lost in low power");
    req_clear_a: assert property (leave_mode |=> pwr_ctrl == 2'h0)
        else $error("power request not cleared");
    idle_enter_a: assert property ((state == cmpc_pkg::CMPC_RUN && pwr_ctrl == 2'h1 && !rst_acc)
        |=> state == cmpc_pkg::CMPC_IDLE)
        else $error("idle not entered");
    idle_exit_a: assert property ((state == cmpc_pkg::CMPC_IDLE && irq_pending)
        |=> state == cmpc_pkg::CMPC_RUN)
        else $error("idle not left on interrupt");
    idle_mc_a: assert property ((state == cmpc_pkg::CMPC_IDLE) |-> !machine_cycle_en)
        else $error("cpu ran in idle");
    pd_osc_a: assert property ((state == cmpc_pkg::CMPC_PD && !rst_s2) |-> !osc_enable)
        else $error("oscillator ran in power down");
    pd_periph_a: assert property (!osc_enable |-> !watchdog_clk_en && !counter_array_clk_en)
        else $error("peripheral clocked with oscillator off");
    wake_osc_a: assert property ((state == cmpc_pkg::CMPC_WAKE) |-> osc_enable)
        else $error("oscillator off while waking");
    wake_exit_a: assert property ((state == cmpc_pkg::CMPC_WAKE && !irq_low)
        |=> state == cmpc_pkg::CMPC_RUN)
        else $error("wake did not complete");
    rst_cpu_a: assert property (rst_acc |-> !cpu_run)
        else $error("cpu ran during reset");
    mc_strobe_a: assert property (machine_cycle_en |=> !machine_cycle_en)
        else $error("machine strobe too long");
    ds_off_a: assert property ((!double_speed_fuse && !clock_divider_config[0])
        |-> !double_speed_active)
        else $error("double speed without source");
    mc_fast_a: assert property (double_speed_active
        |-> machine_cycle_en == (tick6 & osc_enable & cpu_run))
        else $error("machine cycle not at fast rate");
    serial_fix_a: assert property (serial_fixed_mode |-> serial_clk_en == periph_en[3])
        else $error("serial divider ignored");
    fast_t2_a: assert property ((double_speed_active && !clock_divider_config[3])
        |-> (timer2_clk_en == (tick6 & osc_enable)))
        else $error("timer2 fast select ignored");
endmodule

/* File: testbench/cmpc_partner.sv */
// Purpose: Model of the external reset source and interrupt pins
// Assumes: Pulses on reset_go and wake_go are one cycle long
// Notes: Holds are longer than the minimum to cover the synchroniser
`timescale 1ns/100ps
module cmpc_partner (
    input wire logic clk_sys,
    input wire logic reset_go,
    input wire logic wake_go,
    output logic reset_pin,
    output logic ext_irq_0_n,
    output logic ext_irq_1_n
);
    logic [5:0] rst_cnt = 6'h00;
    logic [5:0] irq_cnt = 6'h00;
    always_ff @(posedge clk_sys) begin
        if (reset_go) begin
            rst_cnt <= 6'h20;
        end else if (rst_cnt != 6'h00) begin
            rst_cnt <= rst_cnt - 6'h01;
        end
        if (wake_go) begin
            irq_cnt <= 6'h20;
        end else if (irq_cnt != 6'h00) begin
            irq_cnt <= irq_cnt - 6'h01;
        end
    end
    // 32 cycles: past two slow machine cycles plus sync
    assign reset_pin = (rst_cnt != 6'h00);
    // Level-sensitive low, then returned high to finish the exit
    assign ext_irq_0_n = (irq_cnt == 6'h00);
    assign ext_irq_1_n = 1'h1;
endmodule

/* File: testbench/cmpc_top_test.sv */
// Purpose: Self-checking bench for the clock mode and power block
// Assumes: 25 MHz clock, partner model drives reset and interrupt pins
// Notes: Register bus driven by NB assignment after each rising edge
`timescale 1ns/100ps
module cmpc_top_test;
    logic clk_sys = 1'h0, rst_n = 1'h0, fuse = 1'h0, ea_pin = 1'h0;
    logic irq_pending = 1'h0, fixed = 1'h1, reset_go = 1'h0, wake_go = 1'h0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, rd_val;
    logic wr = 1'h0, rd = 1'h0, reset_pin, irq0_n, irq1_n;
    logic [7:0] rdata;
    logic core_reset, port_reset, ea_latched, cpu_run, osc_enable, mc_en;
    logic wd_en, ca_en, ser_en, t2_en, t1_en, t0_en, ds_active;
    int failures = 0, checks = 0, cycles = 0;
    int n_mc, n_t0, n_t1, n_ser, n_t2, n_ca, n_wd;
    cmpc_partner cmpc_partner_i (.clk_sys(clk_sys), .reset_go(reset_go),
        .wake_go(wake_go), .reset_pin(reset_pin), .ext_irq_0_n(irq0_n),
        .ext_irq_1_n(irq1_n));
    cmpc_top cmpc_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .reset_pin(reset_pin),
        .double_speed_fuse(fuse), .external_access_pin(ea_pin),
        .ext_irq_0_n(irq0_n), .ext_irq_1_n(irq1_n), .irq_pending(irq_pending),
        .serial_fixed_mode(fixed), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .core_reset(core_reset),
        .port_reset(port_reset), .ea_latched(ea_latched), .cpu_run(cpu_run),
        .osc_enable(osc_enable), .machine_cycle_en(mc_en),
        .watchdog_clk_en(wd_en), .counter_array_clk_en(ca_en),
        .serial_clk_en(ser_en), .timer2_clk_en(t2_en), .timer1_clk_en(t1_en),
        .timer0_clk_en(t0_en), .double_speed_active(ds_active));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(logic [1:0] a, logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk_sys);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(logic [1:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk_sys);
        rd <= 1'h0;
        #1 rd_val = rdata;
    endtask
    // 24 cycles hold exactly four /6 strobes or two /12 strobes
    task automatic count24();
        n_mc = 0;
        n_t0 = 0;
        n_t1 = 0;
        n_ser = 0;
        n_t2 = 0;
        n_ca = 0;
        n_wd = 0;
        repeat (24) begin
            @(posedge clk_sys);
            #1;
            n_mc += int'(mc_en === 1'h1);
            n_t0 += int'(t0_en === 1'h1);
            n_t1 += int'(t1_en === 1'h1);
            n_ser += int'(ser_en === 1'h1);
            n_t2 += int'(t2_en === 1'h1);
            n_ca += int'(ca_en === 1'h1);
            n_wd += int'(wd_en === 1'h1);
        end
    endtask
    task automatic rates(int m, int a, int b, int s, int c, int p, int w);
        count24();
        chk("machine", 8'(m), 8'(n_mc));
        chk("timer0", 8'(a), 8'(n_t0));
        chk("timer1", 8'(b), 8'(n_t1));
        chk("serial", 8'(s), 8'(n_ser));
        chk("timer2", 8'(c), 8'(n_t2));
        chk("counter array", 8'(p), 8'(n_ca));
        chk("watchdog", 8'(w), 8'(n_wd));
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        rd_reg(2'h0);
        chk("cfg reset", cmpc_pkg::CLK_DIV_CFG_RESET, rd_val);
        rates(2, 2, 2, 2, 2, 2, 2);
        rd_reg(2'h3);
        chk("unmapped", 8'h00, rd_val);
    endtask
    task automatic t_dividers();
        wr_reg(2'h0, 8'hff);
        rd_reg(2'h0);
        chk("cfg mask", cmpc_pkg::CLK_DIV_CFG_MASK, rd_val);
        wr_reg(2'h0, 8'h45);
        rates(4, 4, 2, 4, 4, 4, 2);
        fixed <= 1'h0;
        rates(4, 4, 2, 0, 4, 4, 2);
        fixed <= 1'h1;
        wr_reg(2'h0, 8'h00);
        rates(2, 2, 2, 2, 2, 2, 2);
        fuse <= 1'h1;
        rates(4, 4, 4, 4, 4, 4, 4);
        chk("ds active", 8'h01, 8'(ds_active));
        fuse <= 1'h0;
        wr_reg(2'h0, 8'h7e);
        rates(2, 2, 2, 2, 2, 2, 2);
    endtask
    task automatic t_reset();
        ea_pin <= 1'h1;
        @(posedge clk_sys);
        reset_go <= 1'h1;
        @(posedge clk_sys);
        reset_go <= 1'h0;
        #1 chk("port reset", 8'h01, 8'(port_reset));
        repeat (19) @(posedge clk_sys);
        #1 chk("early reset", 8'h00, 8'(core_reset));
        repeat (11) @(posedge clk_sys);
        #1 chk("core reset", 8'h01, 8'(core_reset));
        repeat (8) @(posedge clk_sys);
        #1 chk("reset end", 8'h00, 8'(core_reset));
        chk("ea latch", 8'h01, 8'(ea_latched));
        ea_pin <= 1'h0;
        repeat (4) @(posedge clk_sys);
        #1 chk("ea held", 8'h01, 8'(ea_latched));
        rd_reg(2'h0);
        chk("cfg cleared", 8'h00, rd_val);
    endtask
    task automatic t_idle();
        wr_reg(2'h1, 8'h01);
        rd_reg(2'h2);
        chk("idle state", 8'h01, rd_val & 8'h03);
        chk("cpu halted", 8'h00, 8'(cpu_run));
        rates(0, 2, 2, 2, 2, 2, 2);
        irq_pending <= 1'h1;
        repeat (3) @(posedge clk_sys);
        irq_pending <= 1'h0;
        rd_reg(2'h2);
        chk("idle exit", 8'h00, rd_val & 8'h03);
    endtask
    task automatic t_power_down();
        wr_reg(2'h0, 8'h03);
        wr_reg(2'h1, 8'h03);
        rd_reg(2'h2);
        chk("pd state", 8'h03, rd_val & 8'h03);
        chk("osc off", 8'h00, 8'(osc_enable));
        rates(0, 0, 0, 0, 0, 0, 0);
        @(posedge clk_sys);
        wake_go <= 1'h1;
        @(posedge clk_sys);
        wake_go <= 1'h0;
        repeat (8) @(posedge clk_sys);
        #1 chk("osc on", 8'h01, 8'(osc_enable));
        rd_reg(2'h2);
        chk("wake state", 8'h02, rd_val & 8'h03);
        repeat (30) @(posedge clk_sys);
        rd_reg(2'h2);
        chk("run again", 8'h00, rd_val & 8'h03);
        rd_reg(2'h0);
        chk("cfg kept", 8'h03, rd_val);
        rd_reg(2'h1);
        chk("req cleared", 8'h00, rd_val);
    endtask
    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic summarize();
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'h1;
        t_defaults();
        t_dividers();
        t_reset();
        t_idle();
        t_power_down();
        summarize();
    end
endmodule
